/* design/core_params.svh */
`ifndef CORE_PARAMS_SVH
`define CORE_PARAMS_SVH

// Data path width and register count.
`define XLEN 64
`define NREGS 32

// Program counter reset value, step and exception entry point.
`define PC_RESET 64'h0000000000000000
`define PC_STEP 64'h0000000000000004
`define EXC_VECTOR 64'h0000000000000180

// Multiply/divide latencies in pipeline cycles (6, 7, 42, 74).
`define MD_CNT_W 7
`define MUL32_CYC 7'h06
`define MUL64_CYC 7'h07
`define DIV32_CYC 7'h2a
`define DIV64_CYC 7'h4a
`define MD_CNT_ONE 7'h01
`endif

/* design/core_pkg.sv */
`include "core_params.svh"
`default_nettype none
package core_pkg;
    // Operations understood by the integer core.
    typedef enum logic [3:0] {
        OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_SLT, OP_SLL,
        OP_SRL, OP_SRA, OP_LOAD, OP_STORE, OP_MULT, OP_DIV, OP_MOVE_FROM_HIGH_RESULT,
        OP_MOVE_FROM_LOW_RESULT
    } op_type;

    // One decoded instruction as it is issued.
    typedef struct packed {
        op_type op;
        logic dword;
        logic only64;
        logic use_imm;
        logic [4:0] rs;
        logic [4:0] rt;
        logic [4:0] rd;
        logic [`XLEN-1:0] imm;
    } instr_type;

    // Issue latch and register-read stage contents.
    typedef struct packed {
        logic valid;
        instr_type ins;
    } fetch_type;

    // Execute stage contents with resolved operands.
    typedef struct packed {
        logic valid;
        instr_type ins;
        logic [`XLEN-1:0] a;
        logic [`XLEN-1:0] b;
        logic [`XLEN-1:0] c;
    } stage_type;

    // Memory and write-back stage contents.
    typedef struct packed {
        logic valid;
        logic wr;
        logic load;
        logic [4:0] rd;
        logic [`XLEN-1:0] res;
    } res_type;

    // Request seen by the data cache and translation together.
    typedef struct packed {
        logic valid;
        logic write;
        logic [`XLEN-1:0] vaddr;
        logic [`XLEN-1:0] wdata;
    } mem_req_type;

    // Retired register write.
    typedef struct packed {
        logic valid;
        logic [4:0] rd;
        logic [`XLEN-1:0] data;
    } commit_type;

    // Multiply/divide unit states.
    typedef enum logic [1:0] {
        MD_IDLE = 2'b01,
        MD_BUSY = 2'b10
    } md_state_type;
endpackage : core_pkg
`default_nettype wire

/* design/int_alu.sv */
`timescale 1ns/10ps
`default_nettype none
module int_alu
    import core_pkg::*;
(
    // Operation select.
    input wire op_type op,
    // Operands; b already holds the immediate when one is used.
    input wire logic [63:0] a,
    input wire logic [63:0] b,
    // Result, settled inside the execute cycle.
    output logic [63:0] res
);
    logic sub; // Adder subtracts.
    logic [63:0] sum; // Adder output.
    logic [63:0] lres; // Logic unit output.

    // The adder serves arithmetic and address generation alike.
    always_comb begin
        sub = op inside {OP_SUB, OP_SLT};
        sum = a + (sub ? ~b : b) + {63'h0, sub};
    end

    // The logic unit carries every logical operation and every shift.
    always_comb begin
        case (op)
            OP_AND: lres = a & b;
            OP_OR: lres = a | b;
            OP_XOR: lres = a ^ b;
            OP_SLL: lres = a << b[5:0];
            OP_SRL: lres = a >> b[5:0];
            OP_SRA: lres = $signed(a) >>> b[5:0];
            default: lres = '0;
        endcase
    end

    // Pick the unit; loads and stores use the adder for their address.
    always_comb begin
        if (op inside {OP_AND, OP_OR, OP_XOR, OP_SLL, OP_SRL, OP_SRA}) begin
            res = lres;
        end else if (op == OP_SLT) begin
            // Signed compare from the subtraction sign, corrected on overflow.
            res = {63'h0, (a[63] ^ b[63]) ? a[63] : sum[63]};
        end else begin
            res = sum;
        end
    end
endmodule : int_alu
`default_nettype wire

/* design/int_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"
module int_core
    import core_pkg::*;
(
    // Clock and synchronous reset.
    input wire logic clk,
    input wire logic rst,
    // Instruction issue.
    input wire logic issue_valid,
    input wire instr_type issue_ins,
    output logic issue_ready_r,
    output logic [63:0] pc_r,
    // Processor mode pin, high selects 32-bit operation.
    input wire logic mode32_pin,
    // Data cache and translation request, load data one cycle later.
    output mem_req_type mem_req_r,
    input wire logic [63:0] mem_rdata,
    // Retired writes and events.
    output commit_type commit_r,
    output logic exc_r,
    output logic md_busy_r
);
    fetch_type is_r; // Issue latch.
    fetch_type skid_r; // Holds one issue taken while stalled.
    fetch_type rd_r; // Register read and decode stage.
    stage_type ex_r; // Execute stage.
    res_type mem_r; // Memory stage.
    res_type wb_r; // Write-back stage.
    logic [63:0] gpr [`NREGS]; // General registers; entry zero unused.
    logic [63:0] high_result_register; // Multiply high or remainder.
    logic [63:0] low_result_register; // Multiply low or quotient.
    logic [63:0] pend_hi_r; // Result held until the latency expires.
    logic [63:0] pend_lo_r;
    logic [`MD_CNT_W-1:0] md_cnt_r; // Cycles left on multiply/divide.
    md_state_type md_state_r;
    logic m32_s1_r; // Mode pin synchroniser, first stage.
    logic m32_s2_r; // Mode pin synchroniser, second stage.
    logic stall, accept, exc_now, reads_rt, lu_ex, lu_mem, md_wait;
    logic md_go;
    logic [`MD_CNT_W-1:0] md_lat;
    logic [63:0] op_a, op_b, op_c, alu_res, ex_res, wb_val, md_hi, md_lo;
    logic signed [127:0] prod_d;
    logic signed [63:0] prod_w;
    logic signed [63:0] quo_d, rem_d;
    logic signed [31:0] quo_w, rem_w;
    // Operations that leave a result in a general register.
    function automatic logic writes_gpr(input op_type op);
        return !(op inside {OP_NOP, OP_STORE, OP_MULT, OP_DIV});
    endfunction : writes_gpr
    // Operations that start the multiply/divide unit.
    function automatic logic is_md(input op_type op);
        return op inside {OP_MULT, OP_DIV};
    endfunction : is_md
    // Moves out of the high/low result registers.
    function automatic logic is_mf(input op_type op);
        return op inside {OP_MOVE_FROM_HIGH_RESULT, OP_MOVE_FROM_LOW_RESULT};
    endfunction : is_mf
    // Newest value of a register, youngest producer first.
    function automatic logic [63:0] fwd(input logic [4:0] r);
        logic [63:0] v;
        v = gpr[r];
        if (wb_r.valid && wb_r.wr && wb_r.rd == r) begin
            v = wb_val;
        end
        if (mem_r.valid && mem_r.wr && !mem_r.load && mem_r.rd == r) begin
            v = mem_r.res;
        end
        if (ex_r.valid && writes_gpr(ex_r.ins.op) &&
            ex_r.ins.op != OP_LOAD && ex_r.ins.rd == r) begin
            v = ex_res;
        end
        if (r == 5'h00) begin
            v = '0;
        end
        return v;
    endfunction : fwd
    // Hazards. Load data is forwardable only once it reaches write-back,
    // so a consumer waits while its load sits in execute or memory.
    always_comb begin
        reads_rt = !rd_r.ins.use_imm || rd_r.ins.op == OP_STORE;
        lu_ex = ex_r.valid && ex_r.ins.op == OP_LOAD &&
                ex_r.ins.rd != 5'h00 && (ex_r.ins.rd == rd_r.ins.rs ||
                (reads_rt && ex_r.ins.rd == rd_r.ins.rt));
        lu_mem = mem_r.valid && mem_r.load && mem_r.wr &&
                 (mem_r.rd == rd_r.ins.rs ||
                 (reads_rt && mem_r.rd == rd_r.ins.rt));
        // Moves and new multiplies or divides wait for the unit to go idle.
        md_wait = (is_mf(rd_r.ins.op) || is_md(rd_r.ins.op)) &&
                  (md_state_r == MD_BUSY ||
                  (ex_r.valid && is_md(ex_r.ins.op)));
        stall = rd_r.valid && (lu_ex || lu_mem || md_wait);
        exc_now = rd_r.valid && !stall && rd_r.ins.only64 &&
                  m32_s2_r;
        accept = issue_valid && issue_ready_r;
    end
    // Operand read in the decode stage through the bypass network.
    always_comb begin
        op_a = fwd(rd_r.ins.rs);
        op_c = fwd(rd_r.ins.rt);
        if (rd_r.ins.op == OP_MOVE_FROM_HIGH_RESULT) begin
            op_a = high_result_register;
        end else if (rd_r.ins.op == OP_MOVE_FROM_LOW_RESULT) begin
            op_a = low_result_register;
        end
        op_b = rd_r.ins.use_imm ? rd_r.ins.imm : op_c;
    end
    // Single-cycle ALU in the execute stage.
    int_alu u_alu (
        .op(ex_r.ins.op),
        .a(ex_r.a),
        .b(ex_r.b),
        .res(alu_res)
    );
    // Moves pass the captured high/low value; load data joins at write-back.
    always_comb begin
        ex_res = is_mf(ex_r.ins.op) ? ex_r.a : alu_res;
        wb_val = wb_r.load ? mem_rdata : wb_r.res;
    end
    // Mode pin comes from outside, so it is synchronised first.
    always_ff @(posedge clk) begin
        if (rst) begin
            m32_s1_r <= 1'b0;
            m32_s2_r <= 1'b0;
        end else begin
            m32_s1_r <= mode32_pin;
            m32_s2_r <= m32_s1_r;
        end
    end
    // Issue latch, skid entry and decode stage. A stall freezes both front
    // stages; the skid entry absorbs the one issue taken before ready drops.
    always_ff @(posedge clk) begin
        if (rst) begin
            is_r <= '0;
            skid_r <= '0;
            rd_r <= '0;
            issue_ready_r <= 1'b0;
        end else if (exc_now) begin
            // Younger work is discarded so the exception stays precise.
            is_r <= '0;
            skid_r <= '0;
            rd_r <= '0;
            issue_ready_r <= 1'b1;
        end else if (!stall) begin
            rd_r <= is_r;
            if (skid_r.valid) begin
                is_r <= skid_r;
                skid_r <= '0;
            end else begin
                is_r <= '{accept, issue_ins};
            end
            issue_ready_r <= 1'b1;
        end else if (accept) begin
            if (!is_r.valid) begin
                is_r <= '{1'b1, issue_ins};
            end else begin
                skid_r <= '{1'b1, issue_ins};
                issue_ready_r <= 1'b0;
            end
        end
    end
    // Program counter follows each taken issue.
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_r <= `PC_RESET;
        end else if (exc_now) begin
            pc_r <= `EXC_VECTOR;
        end else if (accept) begin
            pc_r <= pc_r + `PC_STEP;
        end
    end
    // Execute stage; a stall or an exception inserts a bubble.
    always_ff @(posedge clk) begin
        if (rst) begin
            ex_r <= '0;
            exc_r <= 1'b0;
        end else begin
            ex_r.valid <= rd_r.valid && !stall && !exc_now;
            ex_r.ins <= rd_r.ins;
            ex_r.a <= op_a;
            ex_r.b <= op_b;
            ex_r.c <= op_c;
            exc_r <= exc_now;
        end
    end
    // Memory stage. The virtual address goes to cache and translation in
    // the same cycle, so translation adds no stage of its own.
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_r <= '0;
            mem_req_r <= '0;
        end else begin
            mem_r.valid <= ex_r.valid;
            mem_r.wr <= ex_r.valid && writes_gpr(ex_r.ins.op) &&
                        ex_r.ins.rd != 5'h00;
            mem_r.load <= ex_r.ins.op == OP_LOAD;
            mem_r.rd <= ex_r.ins.rd;
            mem_r.res <= ex_res;
            mem_req_r.valid <= ex_r.valid &&
                (ex_r.ins.op inside {OP_LOAD, OP_STORE});
            mem_req_r.write <= ex_r.ins.op == OP_STORE;
            mem_req_r.vaddr <= alu_res;
            mem_req_r.wdata <= ex_r.c;
        end
    end
    // Write-back stage and the retire report.
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_r <= '0;
            commit_r <= '0;
        end else begin
            wb_r <= mem_r;
            commit_r <= '{wb_r.valid && wb_r.wr, wb_r.rd, wb_val};
        end
    end
    // Register file write port; the zero entry is never stored.
    always_ff @(posedge clk) begin
        if (wb_r.valid && wb_r.wr) begin
            gpr[wb_r.rd] <= wb_val;
        end
    end
    // Multiply/divide results and latency. A zero divisor gives an
    // all-ones quotient and keeps the dividend as remainder.
    always_comb begin
        md_go = ex_r.valid && is_md(ex_r.ins.op);
        prod_d = $signed(ex_r.a) * $signed(ex_r.b);
        prod_w = $signed(ex_r.a[31:0]) * $signed(ex_r.b[31:0]);
        quo_d = '1;
        rem_d = ex_r.a;
        quo_w = '1;
        rem_w = ex_r.a[31:0];
        if (ex_r.b != 64'h0) begin
            quo_d = $signed(ex_r.a) / $signed(ex_r.b);
            rem_d = $signed(ex_r.a) % $signed(ex_r.b);
        end
        if (ex_r.b[31:0] != 32'h0) begin
            quo_w = $signed(ex_r.a[31:0]) / $signed(ex_r.b[31:0]);
            rem_w = $signed(ex_r.a[31:0]) % $signed(ex_r.b[31:0]);
        end
        if (ex_r.ins.op == OP_MULT) begin
            md_lat = ex_r.ins.dword ? `MUL64_CYC : `MUL32_CYC;
            md_hi = ex_r.ins.dword ? prod_d[127:64] :
                    {{32{prod_w[63]}}, prod_w[63:32]};
            md_lo = ex_r.ins.dword ? prod_d[63:0] :
                    {{32{prod_w[31]}}, prod_w[31:0]};
        end else begin
            md_lat = ex_r.ins.dword ? `DIV64_CYC : `DIV32_CYC;
            md_hi = ex_r.ins.dword ? rem_d : {{32{rem_w[31]}}, rem_w};
            md_lo = ex_r.ins.dword ? quo_d : {{32{quo_w[31]}}, quo_w};
        end
    end
    // The unit runs on its own beside the pipeline and only ever writes
    // the high/low result registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            md_state_r <= MD_IDLE;
            md_cnt_r <= '0;
            md_busy_r <= 1'b0;
            pend_hi_r <= '0;
            pend_lo_r <= '0;
            high_result_register <= '0;
            low_result_register <= '0;
        end else begin
            unique case (md_state_r)
                MD_IDLE: begin
                    if (md_go) begin
                        md_state_r <= MD_BUSY;
                        md_cnt_r <= md_lat;
                        md_busy_r <= 1'b1;
                        pend_hi_r <= md_hi;
                        pend_lo_r <= md_lo;
                    end
                end
                MD_BUSY: begin
                    if (md_cnt_r == `MD_CNT_ONE) begin
                        high_result_register <= pend_hi_r;
                        low_result_register <= pend_lo_r;
                        md_state_r <= MD_IDLE;
                        md_busy_r <= 1'b0;
                    end else begin
                        md_cnt_r <= md_cnt_r - `MD_CNT_ONE;
                    end
                end
            endcase
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // A result in execute is caught by its next consumer in decode.
    sequence producer_then_use;
        ex_r.valid && writes_gpr(ex_r.ins.op) && ex_r.ins.op != OP_LOAD &&
        ex_r.ins.rd != 5'h00 && rd_r.valid && !stall && !exc_now &&
        rd_r.ins.rs == ex_r.ins.rd && !is_mf(rd_r.ins.op);
    endsequence
    sequence md_start_div64;
        md_state_r == MD_IDLE && md_go && ex_r.ins.op == OP_DIV &&
        ex_r.ins.dword;
    endsequence
    a_bypass_ex: assert property (
        producer_then_use |=> ex_r.a == $past(ex_res))
        else $error("Operand missed the bypass from execute.");
    a_zero_commit: assert property (
        commit_r.valid |-> commit_r.rd != 5'h00)
        else $error("Write to register zero was retired.");
    a_load_wait: assert property (
        rd_r.valid && lu_ex |-> stall ##1 rd_r.valid)
        else $error("Load consumer was not held.");
    a_div_latency: assert property (
        md_start_div64 |=> md_busy_r && md_cnt_r == 7'h4a)
        else $error("Divide latency count is wrong.");
    a_md_hold: assert property (
        md_busy_r && md_cnt_r > 7'h01 |=> md_busy_r)
        else $error("Unit went idle before the count expired.");
    a_move_wait: assert property (
        rd_r.valid && is_mf(rd_r.ins.op) && md_busy_r |-> stall)
        else $error("Move from high/low did not interlock.");
    a_hilo_update: assert property (
        md_busy_r && md_cnt_r == 7'h01 |=>
        high_result_register == $past(pend_hi_r) && !md_busy_r)
        else $error("High result not loaded at completion.");
    a_mode_exc: assert property (
        exc_now |=> exc_r && !ex_r.valid && pc_r == `EXC_VECTOR)
        else $error("64-bit-only op in 32-bit mode not trapped.");
    a_mem_only_ls: assert property (
        mem_req_r.valid |-> $past(ex_r.valid) &&
        $past(ex_r.ins.op inside {OP_LOAD, OP_STORE}))
        else $error("Memory request from a non-memory op.");
    a_stage_flow: assert property (
        rd_r.valid && !stall && !exc_now |=> ex_r.valid ##1 mem_r.valid
        ##1 wb_r.valid)
        else $error("Instruction did not advance one stage a cycle.");
    a_rf_write: assert property (
        wb_r.valid && wb_r.wr |=> gpr[$past(wb_r.rd)] == $past(wb_val))
        else $error("Register file write lost.");
endmodule : int_core
`default_nettype wire

/* verification/tb_int_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"
module tb_int_core
    import core_pkg::*;
;
    // Clock, reset and the core's ports.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid = 1'b0;
    instr_type issue_ins = '0;
    logic issue_ready_r;
    logic [63:0] pc_r;
    logic mode32_pin = 1'b0;
    mem_req_type mem_req_r;
    logic [63:0] mem_rdata = 64'h0;
    commit_type commit_r;
    logic exc_r;
    logic md_busy_r;
    // Load data returned for every load request.
    localparam logic [63:0] LDV = 64'h0123456789abcdef;
    // Result tallies and the observation queues.
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int busy_cnt = 0;
    int exc_cnt = 0;
    logic [4:0] cq_rd[$];
    logic [63:0] cq_d[$];
    int cq_t[$];
    logic mq_w[$];
    logic [63:0] mq_a[$];
    logic [63:0] mq_d[$];

    int_core u_int_core (
        .clk(clk), .rst(rst), .issue_valid(issue_valid),
        .issue_ins(issue_ins), .issue_ready_r(issue_ready_r), .pc_r(pc_r),
        .mode32_pin(mode32_pin), .mem_req_r(mem_req_r),
        .mem_rdata(mem_rdata), .commit_r(commit_r), .exc_r(exc_r),
        .md_busy_r(md_busy_r)
    );

    // Free-running 250 MHz clock.
    initial begin
        forever #2 clk = ~clk;
    end

    // Memory side: load data the cycle after the request; otherwise the
    // bus toggles so that a stale sample can never look right by chance.
    always @(posedge clk) begin
        if (mem_req_r.valid === 1'b1 && mem_req_r.write === 1'b0) begin
            mem_rdata <= LDV;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end

    // Monitor: records retired writes, memory requests and events.
    always @(posedge clk) begin
        cyc++;
        if (md_busy_r === 1'b1) busy_cnt++;
        if (exc_r === 1'b1) exc_cnt++;
        if (commit_r.valid === 1'b1) begin
            cq_rd.push_back(commit_r.rd);
            cq_d.push_back(commit_r.data);
            cq_t.push_back(cyc);
        end
        if (mem_req_r.valid === 1'b1) begin
            mq_w.push_back(mem_req_r.write);
            mq_a.push_back(mem_req_r.vaddr);
            mq_d.push_back(mem_req_r.wdata);
        end
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // A wait that ran out counts as a mismatch and closes the run.
    task automatic timeout(input string what);
        bad_count++;
        $display("Error %s timed out", what);
        end_of_test();
    endtask : timeout

    // One compare for every 64-bit result kind.
    task automatic chk(input string name, input logic [63:0] exp,
                       input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Builds one decoded instruction.
    function automatic instr_type mk(input op_type op, input logic dw,
        input logic [4:0] rs, input logic [4:0] rt, input logic [4:0] rd,
        input logic ui, input logic [63:0] imm);
        instr_type i;
        i = '0;
        i.op = op;
        i.dword = dw;
        i.rs = rs;
        i.rt = rt;
        i.rd = rd;
        i.use_imm = ui;
        i.imm = imm;
        return i;
    endfunction : mk

    // Offers one instruction and holds it until the core takes it. Valid
    // stays high so that back-to-back issues need no gap.
    task automatic issue(input instr_type ins);
        int k;
        issue_valid <= 1'b1;
        issue_ins <= ins;
        k = 0;
        @(posedge clk);
        while (issue_ready_r !== 1'b1) begin
            k++;
            if (k > 200) timeout("issue");
            @(posedge clk);
        end
    endtask : issue

    // Withdraws the offer for one cycle.
    task automatic idle();
        issue_valid <= 1'b0;
        @(posedge clk);
    endtask : idle

    // Waits, bounded, until n register writes have retired.
    task automatic wait_commits(input int n);
        int k;
        k = 0;
        while (cq_d.size() < n) begin
            k++;
            if (k > 300) timeout("commit");
            @(posedge clk);
        end
    endtask : wait_commits

    // Dependent back-to-back ALU chain through every operation.
    task automatic s_alu();
        op_type op[13] = '{OP_ADD, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
            OP_SLT, OP_SLL, OP_SRL, OP_SUB, OP_SRA, OP_ADD, OP_ADD};
        logic [4:0] rs[13] = '{0, 1, 2, 1, 1, 2, 3, 1, 2, 0, 5, 1, 0};
        logic [4:0] rt[13] = '{0, 0, 1, 2, 3, 3, 1, 0, 0, 1, 0, 0, 0};
        logic [4:0] rd[13] = '{1, 2, 3, 4, 4, 4, 4, 4, 4, 5, 5, 0, 6};
        logic ui[13] = '{1, 1, 0, 0, 0, 0, 0, 1, 1, 0, 1, 1, 1};
        logic [63:0] im[13] = '{12, 3, 0, 0, 0, 0, 0, 4, 1, 0, 2, 1, 7};
        logic [63:0] ex[13] = '{64'hc, 64'hf, 64'h3, 64'hc, 64'hf, 64'hc,
            64'h1, 64'hc0, 64'h7, 64'hfffffffffffffff4,
            64'hfffffffffffffffd, 64'h0, 64'h7};
        instr_type ins;
        for (int i = 0; i < 13; i++) begin
            ins = mk(op[i], 1'b1, rs[i], rt[i], rd[i], ui[i], im[i]);
            ins.only64 = (i == 12);
            issue(ins);
        end
        idle();
        wait_commits(12);
        // Give a wrongly retired zero-register write time to show up.
        repeat (4) @(posedge clk);
        for (int i = 0; i < 13; i++) begin
            if (i != 11) begin
                chk("alu rd", {59'h0, rd[i]}, {59'h0, cq_rd[i - (i > 11)]});
                chk("alu data", ex[i], cq_d[i - (i > 11)]);
            end
        end
        // Twelve writes plus the dropped one: one retire per cycle.
        chk("alu spacing", 64'd12, 64'(cq_t[11] - cq_t[0]));
        chk("alu r0 dropped", 64'd12, 64'(cq_d.size()));
        chk("pc", `PC_RESET + 64'd13 * `PC_STEP, pc_r);
        $display("Test alu chain done");
    endtask : s_alu

    // Store, then a load with a dependent add right behind it.
    task automatic s_mem();
        int mb;
        int b;
        mb = mq_a.size();
        b = cq_d.size();
        issue(mk(OP_STORE, 1'b1, 5'd1, 5'd2, 5'd0, 1'b1, 64'h10));
        issue(mk(OP_LOAD, 1'b1, 5'd1, 5'd0, 5'd7, 1'b1, 64'h20));
        issue(mk(OP_ADD, 1'b1, 5'd7, 5'd0, 5'd8, 1'b1, 64'h1));
        idle();
        wait_commits(b + 2);
        chk("mem count", 64'd2, 64'(mq_a.size() - mb));
        chk("store write", 64'h1, {63'h0, mq_w[mb]});
        chk("store addr", 64'h1c, mq_a[mb]);
        chk("store data", 64'hf, mq_d[mb]);
        chk("load write", 64'h0, {63'h0, mq_w[mb + 1]});
        chk("load addr", 64'h2c, mq_a[mb + 1]);
        chk("load data", LDV, cq_d[b]);
        chk("load use", LDV + 64'h1, cq_d[b + 1]);
        $display("Test memory done");
    endtask : s_mem

    // Divide and multiply, each read back at once through the moves.
    task automatic s_muldiv();
        int b;
        int b0;
        b = cq_d.size();
        b0 = busy_cnt;
        issue(mk(OP_DIV, 1'b0, 5'd2, 5'd1, 5'd0, 1'b0, 64'h0));
        issue(mk(OP_MOVE_FROM_LOW_RESULT, 1'b0, 5'd0, 5'd0, 5'd9, 1'b0, 64'h0));
        issue(mk(OP_MOVE_FROM_HIGH_RESULT, 1'b0, 5'd0, 5'd0, 5'd10, 1'b0, 64'h0));
        idle();
        wait_commits(b + 2);
        chk("div busy", {57'h0, `DIV32_CYC}, 64'(busy_cnt - b0));
        chk("div quotient", 64'h1, cq_d[b]);
        chk("div remainder", 64'h3, cq_d[b + 1]);
        b0 = busy_cnt;
        issue(mk(OP_MULT, 1'b1, 5'd1, 5'd2, 5'd0, 1'b0, 64'h0));
        issue(mk(OP_MOVE_FROM_LOW_RESULT, 1'b0, 5'd0, 5'd0, 5'd11, 1'b0, 64'h0));
        issue(mk(OP_MOVE_FROM_HIGH_RESULT, 1'b0, 5'd0, 5'd0, 5'd12, 1'b0, 64'h0));
        idle();
        wait_commits(b + 4);
        chk("mul busy", {57'h0, `MUL64_CYC}, 64'(busy_cnt - b0));
        chk("mul low", 64'hb4, cq_d[b + 2]);
        chk("mul high", 64'h0, cq_d[b + 3]);
        chk("mul rd", 64'd12, {59'h0, cq_rd[b + 3]});
        // Doubleword divide, then a word multiply whose add fills the skid.
        b0 = busy_cnt;
        issue(mk(OP_DIV, 1'b1, 5'd2, 5'd4, 5'd0, 1'b0, 64'h0));
        issue(mk(OP_MOVE_FROM_LOW_RESULT, 1'b0, 5'd0, 5'd0, 5'd11, 1'b0, 64'h0));
        issue(mk(OP_MOVE_FROM_HIGH_RESULT, 1'b0, 5'd0, 5'd0, 5'd12, 1'b0, 64'h0));
        idle();
        wait_commits(b + 6);
        chk("d64 busy", {57'h0, `DIV64_CYC}, 64'(busy_cnt - b0));
        chk("d64 quotient", 64'h2, cq_d[b + 4]);
        chk("d64 remainder", 64'h1, cq_d[b + 5]);
        b0 = busy_cnt;
        issue(mk(OP_MULT, 1'b0, 5'd5, 5'd1, 5'd0, 1'b0, 64'h0));
        issue(mk(OP_MOVE_FROM_LOW_RESULT, 1'b0, 5'd0, 5'd0, 5'd11, 1'b0, 64'h0));
        issue(mk(OP_MOVE_FROM_HIGH_RESULT, 1'b0, 5'd0, 5'd0, 5'd12, 1'b0, 64'h0));
        issue(mk(OP_ADD, 1'b1, 5'd0, 5'd0, 5'd14, 1'b1, 64'h5));
        idle();
        chk("skid ready", 64'h0, {63'h0, issue_ready_r});
        wait_commits(b + 9);
        chk("m32 busy", {57'h0, `MUL32_CYC}, 64'(busy_cnt - b0));
        chk("m32 low", 64'hffffffffffffffdc, cq_d[b + 6]);
        chk("m32 high", 64'hffffffffffffffff, cq_d[b + 7]);
        chk("skid add", 64'h5, cq_d[b + 8]);
        repeat (4) @(posedge clk);
        chk("md commits", 64'd9, 64'(cq_d.size() - b));
        $display("Test multiply divide done");
    endtask : s_muldiv

    // A 64-bit-only operation in 32-bit mode traps instead of running.
    task automatic s_mode32();
        int b;
        int e0;
        int k;
        instr_type ins;
        mode32_pin <= 1'b1;
        // The pin passes a two-stage synchroniser first.
        repeat (4) @(posedge clk);
        b = cq_d.size();
        e0 = exc_cnt;
        ins = mk(OP_ADD, 1'b1, 5'd0, 5'd0, 5'd13, 1'b1, 64'h1);
        ins.only64 = 1'b1;
        issue(ins);
        idle();
        k = 0;
        while (exc_cnt == e0) begin
            k++;
            if (k > 20) timeout("exception");
            @(posedge clk);
        end
        repeat (2) idle();
        chk("exc pc", `EXC_VECTOR, pc_r);
        issue(mk(OP_ADD, 1'b0, 5'd0, 5'd0, 5'd15, 1'b1, 64'h9));
        idle();
        wait_commits(b + 1);
        repeat (4) @(posedge clk);
        chk("exc pulses", 64'd1, 64'(exc_cnt - e0));
        chk("exc commits", 64'd1, 64'(cq_d.size() - b));
        chk("after exc rd", 64'd15, {59'h0, cq_rd[b]});
        chk("after exc data", 64'h9, cq_d[b]);
        chk("after exc pc", `EXC_VECTOR + `PC_STEP, pc_r);
        mode32_pin <= 1'b0;
        @(posedge clk);
        $display("Test 32-bit mode done");
    endtask : s_mode32

    // Main sequence: reset for 16 cycles, then every scenario in turn.
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_alu();
        s_mem();
        s_muldiv();
        s_mode32();
        end_of_test();
    end
endmodule : tb_int_core
`default_nettype wire
